// ==== include/esp_pkg.sv ====
// Functional notes
// R1 - Memory holds 1M words of 16 bits, addressed by 20-bit word address.
// R2 - Every read returns data with any single-bit error corrected; the host has no correction and returns the selected lanes of i_dq unchanged.
// R3 - A corrected read leaves the stored array unchanged.
// R4 - Accesses happen only while the active-low chip select is low.
// R5 - A write drives write strobe low with address and data presented.
// R6 - Writes update only enabled byte lanes; upper select governs bits 15..8.
// R7 - A read drives the output gate low with the address presented.
// R8 - On reads only selected byte lanes are driven by the memory.
// R9 - Memory floats data lines when deselected or gate or selects inactive.
// R10 - Wait at least 100 microseconds after power is stable before accessing.
// R11 - Writes occur while strobe, select and a byte select are low.
// R12 - Write strobe stays high for the whole of every read cycle.
// R13 - Host never drives data lines while the memory drives them.
// R14 - Address and byte selects stay stable for the whole access.
package esp_pkg;
  localparam int unsigned ADDR_W       = 20;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned POWER_US     = 100;
  localparam int unsigned POWER_CYC    = POWER_US * CLK_MHZ;
  localparam int unsigned CYCLE_NS     = 10;
  localparam int unsigned ACCESS_NS    = 20;
  localparam int unsigned ACCESS_CYC   = (ACCESS_NS + CYCLE_NS - 1) / CYCLE_NS;
  localparam int unsigned CNT_W        = 16;

  typedef enum logic [2:0] {
    ESP_WAIT_POWER = 3'h0,
    ESP_IDLE       = 3'h1,
    ESP_SETUP      = 3'h3,
    ESP_STROBE     = 3'h2,
    ESP_RELEASE    = 3'h6
  } esp_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        byte_en;
    logic              write;
  } esp_req_s;

  typedef struct packed {
    logic              chip_sel_n;
    logic              write_n;
    logic              out_gate_n;
    logic              upper_byte_sel_n;
    logic              lower_byte_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } esp_pins_s;
endpackage

// ==== hw/esp_host.sv ====
module esp_host
  import esp_pkg::*;
#(
  parameter int unsigned POWER_WAIT_CYC = POWER_CYC,
  parameter int unsigned STROBE_CYC     = ACCESS_CYC
) (
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  input  wire logic              i_req_valid,
  input  wire esp_req_s          i_req,
  output logic                   o_req_ready,
  output logic                   o_rd_valid,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_powered,
  output esp_pins_s              o_pins,
  input  wire logic [DATA_W-1:0] i_dq
);
  // Refuses counts that the cycle counter cannot reach.
  if (POWER_WAIT_CYC < 1 || POWER_WAIT_CYC >= (1 << CNT_W)) begin : g_bad_power
    $error("POWER_WAIT_CYC out of range");
  end
  if (STROBE_CYC < 1 || STROBE_CYC >= (1 << CNT_W)) begin : g_bad_strobe
    $error("STROBE_CYC out of range");
  end

  localparam int unsigned LANE_W = DATA_W / 2;

  typedef struct packed {
    esp_state_e        state;
    logic [CNT_W-1:0]  cnt;
    esp_pins_s         pins;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
  } esp_host_s;

  esp_host_s st;
  esp_host_s next_st;

  localparam esp_pins_s PINS_IDLE = '{chip_sel_n: 1'b1, write_n: 1'b1, out_gate_n: 1'b1,
                                     upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1,
                                     addr: '0, dq_out: '0, dq_oe: 1'b0};

  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    unique case (st.state)
      ESP_WAIT_POWER: begin
        // R10 power-up wait.
        if (st.cnt == CNT_W'(POWER_WAIT_CYC - 1)) begin
          next_st.state = ESP_IDLE;
          next_st.cnt = '0;
        end else begin
          next_st.cnt = st.cnt + CNT_W'(1);
        end
      end
      ESP_IDLE: begin
        if (i_req_valid && i_req.byte_en != 2'h0) begin
          // R14 hold address, selects.
          next_st.pins.addr = i_req.addr;
          next_st.pins.upper_byte_sel_n = ~i_req.byte_en[1];
          next_st.pins.lower_byte_sel_n = ~i_req.byte_en[0];
          next_st.pins.dq_out = i_req.wdata;
          // R13 drive only writes.
          next_st.pins.dq_oe = i_req.write;
          // R4 select for access.
          next_st.pins.chip_sel_n = 1'b0;
          // R12 strobe high reads.
          next_st.pins.write_n = 1'b1;
          next_st.pins.out_gate_n = 1'b1;
          next_st.state = ESP_SETUP;
          next_st.cnt = '0;
        end
      end
      ESP_SETUP: begin
        if (st.pins.dq_oe) begin
          // R5 write strobe low.
          next_st.pins.write_n = 1'b0;
        end else begin
          // R7 read gate low.
          next_st.pins.out_gate_n = 1'b0;
        end
        next_st.state = ESP_STROBE;
      end
      ESP_STROBE: begin
        if (st.cnt == CNT_W'(STROBE_CYC - 1)) begin
          // R11 rising strobe ends write.
          next_st.pins.write_n = 1'b1;
          next_st.pins.out_gate_n = 1'b1;
          if (!st.pins.dq_oe) begin
            // R8 keep only selected lanes.
            next_st.rd_data = {st.pins.upper_byte_sel_n ? {LANE_W{1'b0}} : i_dq[DATA_W-1:LANE_W],
                               st.pins.lower_byte_sel_n ? {LANE_W{1'b0}} : i_dq[LANE_W-1:0]};
            next_st.rd_valid = 1'b1;
          end
          next_st.state = ESP_RELEASE;
        end else begin
          next_st.cnt = st.cnt + CNT_W'(1);
        end
      end
      ESP_RELEASE: begin
        next_st.pins = PINS_IDLE;
        next_st.pins.addr = st.pins.addr;
        next_st.state = ESP_IDLE;
        next_st.cnt = '0;
      end
      default: begin
        next_st.state = ESP_IDLE;
        next_st.pins = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '{state: ESP_WAIT_POWER, cnt: '0, pins: PINS_IDLE, rd_valid: 1'b0, rd_data: '0};
    end else begin
      st <= next_st;
    end
  end

  assign o_req_ready = (st.state == ESP_IDLE);
  assign o_rd_valid = st.rd_valid;
  assign o_rd_data = st.rd_data;
  assign o_powered = (st.state != ESP_WAIT_POWER);
  assign o_pins = st.pins;
endmodule

// ==== test/esp_host_chk.sv ====
module esp_host_chk
  import esp_pkg::*;
#(parameter int unsigned STROBE_CYC = ACCESS_CYC) (
  input wire logic      i_clock,
  input wire logic      i_rstn,
  input wire logic      i_req_valid,
  input wire esp_req_s  i_req,
  input wire logic      o_req_ready,
  input wire logic      o_rd_valid,
  input wire esp_pins_s o_pins
);
  localparam int RL = 2 + STROBE_CYC;
  wire take = i_req_valid && o_req_ready && (i_req.byte_en != 2'h0);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  chk_write_sel: assert property (!o_pins.write_n |-> !o_pins.chip_sel_n)
    else $error("write strobe without chip select");
  chk_read_we_high: assert property (!o_pins.out_gate_n |-> o_pins.write_n)
    else $error("write strobe low during read");
  chk_no_contend: assert property (!o_pins.out_gate_n |-> !o_pins.dq_oe)
    else $error("host drives data while memory drives");
  chk_idle_desel: assert property (o_req_ready |-> o_pins.chip_sel_n)
    else $error("chip selected while idle");
  chk_take_lanes: assert property (take |=> !o_pins.chip_sel_n &&
    {o_pins.upper_byte_sel_n, o_pins.lower_byte_sel_n} == ~$past(i_req.byte_en))
    else $error("lane selects do not follow request");
  chk_read_answer: assert property (take && !i_req.write |-> ##RL o_rd_valid)
    else $error("read answer late");
  chk_addr_hold: assert property (!o_pins.chip_sel_n && !$past(o_pins.chip_sel_n)
    |-> $stable(o_pins.addr)) else $error("address moved in access");
  chk_write_drive: assert property (!o_pins.write_n |-> o_pins.dq_oe)
    else $error("write strobe without data drive");
endmodule

// ==== test/esp_mem_model.sv ====
module esp_mem_model
  import esp_pkg::*;
(
  input  wire esp_pins_s    i_pins,
  output logic [DATA_W-1:0] o_dq
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] flt = 16'hA5A5;
  always @(i_pins.addr or i_pins.out_gate_n) flt = ~flt;
  always @(posedge i_pins.write_n) if (!i_pins.chip_sel_n) begin
    if (!i_pins.lower_byte_sel_n) mem[i_pins.addr][7:0] = i_pins.dq_out[7:0];
    if (!i_pins.upper_byte_sel_n) mem[i_pins.addr][15:8] = i_pins.dq_out[15:8];
  end
  always @* begin
    o_dq = flt;
    if (!i_pins.chip_sel_n && !i_pins.out_gate_n && i_pins.write_n) begin
      if (!i_pins.lower_byte_sel_n) o_dq[7:0] = mem[i_pins.addr][7:0];
      if (!i_pins.upper_byte_sel_n) o_dq[15:8] = mem[i_pins.addr][15:8];
    end
  end
endmodule

// ==== test/esp_host_test.sv ====
module esp_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import esp_pkg::*;
  logic i_clock = 0, i_rstn = 0, i_req_valid = 0, o_req_ready, o_rd_valid, o_powered;
  logic [DATA_W-1:0] o_rd_data, mem_dq, i_dq;
  esp_req_s  i_req = '0;
  esp_pins_s o_pins;
  int n_errors = 0, samples_checked = 0, i;
  logic [DATA_W-1:0] model [int];
  always #5 i_clock = ~i_clock;
  assign i_dq = o_pins.dq_oe ? o_pins.dq_out : mem_dq;
  esp_host #(.POWER_WAIT_CYC(4), .STROBE_CYC(2)) dut (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_powered(o_powered),
    .o_pins(o_pins), .i_dq(i_dq));
  esp_mem_model mem (.i_pins(o_pins), .o_dq(mem_dq));
  task check(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task req(logic w, int a, logic [15:0] d, logic [1:0] be);
    int k;
    logic [15:0] e;
    @(posedge i_clock);
    #1 i_req_valid = 1;
    i_req = '{a[19:0] ^ (a[0] ? 20'hFFFFF : 20'h0), d, be, w};
    for (k = 0; k < 20 && o_req_ready !== 1'b1; k++) @(posedge i_clock) #1;
    @(posedge i_clock);
    #1 i_req_valid = 0;
    e = 16'h0;
    if (!model.exists(a)) model[a] = 16'h0;
    if (be[0]) e[7:0] = w ? d[7:0] : model[a][7:0];
    if (be[1]) e[15:8] = w ? d[15:8] : model[a][15:8];
    if (w) model[a] = (model[a] & ~{{8{be[1]}}, {8{be[0]}}}) | e;
    if (w) return;
    for (k = 0; k < 10 && o_rd_valid !== 1'b1; k++) @(posedge i_clock) #1;
    check("read valid", 16'h1, {15'h0, o_rd_valid});
    check("read data", e, o_rd_data);
  endtask
  initial begin
    void'($urandom(32'hFF0A));
    repeat (10) @(posedge i_clock);
    #1 i_rstn = 1;
    check("ready before power wait", 16'h0, {15'h0, o_req_ready});
    for (i = 0; i < 8; i++) req(1, i, $urandom, 2'h3);
    for (i = 0; i < 60; i++) req($urandom % 2, $urandom % 8, $urandom, 1 + $urandom % 3);
    check("powered", 16'h1, {15'h0, o_powered});
    finish_test;
  end
  initial begin
    #50000 n_errors++;
    finish_test;
  end
endmodule
bind esp_host esp_host_chk #(.STROBE_CYC(STROBE_CYC)) chk (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready),
  .o_rd_valid(o_rd_valid), .o_pins(o_pins));
